// >>> hdl/quad_dac_ctrl.sv
// Serial command decoder for power, reset and reference control with power-on behaviour.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
//
// What this block does
// - Power command 100 carries mode in bits 5..4, channel selects D..A in bits 3..0.
// - Variant without strap pin starts every output at zero volts.
// - With strap pin: ground gives zero start, supply gives midscale start.
// - Outputs hold startup level until a complete valid write arrives.
// - Load and clear pin events are ignored during power-on reset.
// - Command 101 is software reset; bit 0 picks its depth.
// - Depth 0 clears DAC and shift registers; depth 1 also mask, power, reference.
// - Internal reference enable is cleared after power-up.
// - Command 111 loads reference enable from bit 0.
// - Mode 00 normal, 01 1k pull-down, 10 100k pull-down, 11 high impedance.
// - Only selected channels change power state; others keep theirs.
// - Power-down never disturbs stored DAC register contents.
module quad_dac_ctrl #(
  parameter bit HAS_STRAP_PIN = 1'b1
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // Avalon-MM register slave
  input  wire logic [quad_dac_pkg::AV_ADDR_W-1:0] address,
  input  wire logic                             read,
  input  wire logic                             write,
  input  wire logic [31:0]                      writedata,
  output logic      [31:0]                      readdata,
  output logic                                  waitrequest,
  // Serial link, open drain data
  input  wire logic                             scl_in,
  input  wire logic                             sda_in,
  output logic                                  sda_out,
  output logic                                  sda_oe,
  // Device pins
  input  wire logic                             startup_level_pin,
  input  wire logic                             load_strobe_pin_n,
  input  wire logic                             output_clear_pin_n,
  // Control outputs to the converter core
  output logic      [7:0]                       power_mode,
  output logic                                  ref_enable,
  output logic                                  hold_startup,
  output logic                                  startup_midscale,
  output logic                                  por_busy,
  output logic                                  dac_clear,
  output logic                                  full_reset,
  output logic                                  load_evt,
  output logic                                  clear_evt
);
  import quad_dac_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_DATA = 3'b010,
    ST_ACK  = 3'b011,
    ST_SKIP = 3'b100
  } link_state_t;

  link_state_t state;
  logic [2:0]  scl_sync;
  logic [2:0]  sda_sync;
  logic [1:0]  strap_sync;
  logic [2:0]  load_sync;
  logic [2:0]  clear_sync;
  logic [7:0]  shift;
  logic [3:0]  bit_cnt;
  logic [1:0]  byte_idx;
  logic [23:0] frame_buf;
  frame_t      frame;
  logic        frame_valid;
  logic [7:0]  por_cnt;
  logic [31:0] control;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;

  function automatic logic is_cmd(input frame_t f, input logic [2:0] code);
    return f.command_code == code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers; only the second stage onward is looked at.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync   <= 3'h7;
      sda_sync   <= 3'h7;
      strap_sync <= 2'h0;
      load_sync  <= 3'h7;
      clear_sync <= 3'h7;
    end else begin
      scl_sync   <= {scl_sync[1:0], scl_in};
      sda_sync   <= {sda_sync[1:0], sda_in};
      strap_sync <= {strap_sync[0], startup_level_pin};
      load_sync  <= {load_sync[1:0], load_strobe_pin_n};
      clear_sync <= {clear_sync[1:0], output_clear_pin_n};
    end
  end

  assign scl_rise   = scl_sync[1] & ~scl_sync[2];
  assign scl_fall   = ~scl_sync[1] & scl_sync[2];
  assign start_cond = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on reset timer and strap capture.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt          <= 8'h00;
      por_busy         <= 1'b1;
      startup_midscale <= 1'b0;
    end else if (por_busy) begin
      por_cnt <= por_cnt + 8'h01;
      if (por_cnt == POR_CNT_MAX - 8'h01) begin
        por_busy         <= 1'b0;
        startup_midscale <= HAS_STRAP_PIN & strap_sync[1];
      end
    end
  end

  // Pin strobes are falling edges of the active-low pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_evt  <= 1'b0;
      clear_evt <= 1'b0;
    end else begin
      load_evt  <= ~por_busy & load_sync[2] & ~load_sync[1];
      clear_evt <= ~por_busy & clear_sync[2] & ~clear_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial slave. A frame commits at the falling clock that ends the acknowledge
  // of the third data byte; a stop or repeated start before then drops the partial frame.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      shift       <= 8'h00;
      bit_cnt     <= 4'h0;
      byte_idx    <= 2'h0;
      frame_buf   <= 24'h00_0000;
      frame       <= '0;
      frame_valid <= 1'b0;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
    end else begin
      frame_valid <= 1'b0;
      if (start_cond) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        sda_oe   <= 1'b0;
      end else if (stop_cond) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_DATA: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shift   <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == ST_DATA) begin
                frame_buf <= {frame_buf[15:0], shift};
                byte_idx  <= byte_idx + 2'h1;
                sda_oe    <= 1'b1;
                state     <= ST_ACK;
              end else if (shift[7:1] == I2C_ADDR && !shift[0] && control[0]) begin
                sda_oe <= 1'b1;
                state  <= ST_ACK;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state  <= ST_DATA;
              if (byte_idx == 2'h3) begin
                byte_idx    <= 2'h0;
                frame       <= frame_t'(frame_buf);
                frame_valid <= 1'b1;
                if (is_cmd(frame_t'(frame_buf), CMD_RESET)) begin
                  frame_buf <= 24'h00_0000;
                end
              end
            end
          end
          ST_IDLE, ST_SKIP: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode. Reserved, byte select and address bits are never looked at,
  // so reset and reference commands act device-wide. Power commands touch only
  // output state, never DAC codes, so codes survive a power-down.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode <= POWER_RESET;
      ref_enable <= 1'b0;
      dac_clear  <= 1'b0;
      full_reset <= 1'b0;
    end else begin
      dac_clear  <= 1'b0;
      full_reset <= 1'b0;
      if (frame_valid && is_cmd(frame, CMD_POWER)) begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (frame.data[ch]) begin
            power_mode[2*ch +: 2] <= frame.data[PM_HI_POS:PM_LO_POS];
          end
        end
      end else if (frame_valid && is_cmd(frame, CMD_RESET)) begin
        dac_clear <= 1'b1;
        if (frame.data[MODE_BIT]) begin
          full_reset <= 1'b1;
          power_mode <= POWER_RESET;
          ref_enable <= 1'b0;
        end
      end else if (frame_valid && is_cmd(frame, CMD_REF_SETUP)) begin
        ref_enable <= frame.data[MODE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_startup <= 1'b1;
    end else if (frame_valid && frame.command_code <= CMD_WRITE_LAST) begin
      hold_startup <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: waitrequest drops for one cycle, one cycle after a request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      case (address)
        OFS_STATUS:  readdata <= {20'h0_0000, startup_midscale, por_busy, hold_startup,
                                  ref_enable, power_mode};
        OFS_CONTROL: readdata <= control;
        OFS_FRAME:   readdata <= {8'h00, frame};
        default:     readdata <= 32'h0000_0000;
      endcase
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= CONTROL_RESET;
    end else if (write && !waitrequest && address == OFS_CONTROL) begin
      control <= {31'h0000_0000, writedata[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [8:0] age;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 9'h000;
    end else if (age != 9'h1ff) begin
      age <= age + 9'h001;
    end
  end

  a_por_length: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(por_busy) |-> age == 9'(POR_CYCLES))
    else $error("power-on reset length wrong");
  a_load_gated: assert property (@(posedge clk) disable iff (!rst_n)
    (load_evt || clear_evt) |-> !$past(por_busy))
    else $error("pin event passed during power-on reset");
  a_strap_level: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(por_busy) |-> startup_midscale == (HAS_STRAP_PIN && $past(strap_sync[1])))
    else $error("startup level not taken from strap");
  a_power_apply: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is_cmd(frame, CMD_POWER) && frame.data[0]
    |=> power_mode[1:0] == $past(frame.data[5:4]))
    else $error("selected channel power mode not loaded");
  a_power_keep: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is_cmd(frame, CMD_POWER) && !frame.data[3]
    |=> $stable(power_mode[7:6]))
    else $error("unselected channel changed");
  a_ref_load: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is_cmd(frame, CMD_REF_SETUP) |=> ref_enable == $past(frame.data[0]))
    else $error("reference enable not loaded");
  a_full_reset: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is_cmd(frame, CMD_RESET) && frame.data[0]
    |=> full_reset && dac_clear && power_mode == POWER_RESET && !ref_enable)
    else $error("full software reset incomplete");
  a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid && is_cmd(frame, CMD_RESET) && !frame.data[0]
    |=> dac_clear && !full_reset && $stable(power_mode))
    else $error("shallow software reset wrong");
  a_hold_level: assert property (@(posedge clk) disable iff (!rst_n)
    hold_startup && !(frame_valid && frame.command_code <= CMD_WRITE_LAST) |=> hold_startup)
    else $error("startup hold released without write");
  a_frame_acked: assert property (@(posedge clk) disable iff (!rst_n)
    frame_valid |-> $past(state) == ST_ACK && $past(scl_fall) && $past(byte_idx) == 2'h3)
    else $error("frame committed before third acknowledge");
  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered");

endmodule

// >>> hdl/quad_dac_pkg.sv
// Constants, command codes and frame layout for the quad converter control block.
package quad_dac_pkg;

  // Serial command codes.
  localparam logic [2:0] CMD_WRITE_LAST = 3'h3;
  localparam logic [2:0] CMD_POWER      = 3'h4;
  localparam logic [2:0] CMD_RESET      = 3'h5;
  localparam logic [2:0] CMD_MASK_SETUP = 3'h6;
  localparam logic [2:0] CMD_REF_SETUP  = 3'h7;

  // Per-channel output state.
  typedef enum logic [1:0] {
    PM_NORMAL   = 2'h0,
    PM_PULL_1K  = 2'h1,
    PM_PULL_100K = 2'h2,
    PM_HIGH_Z   = 2'h3
  } power_mode_t;

  // One 24-bit command word, most significant bit first on the wire.
  typedef struct packed {
    logic        reserved;
    logic        byte_select;
    logic [2:0]  command_code;
    logic [2:0]  channel_address;
    logic [15:0] data;
  } frame_t;

  // Field positions inside the data half of a frame.
  localparam int PM_HI_POS   = 5;
  localparam int PM_LO_POS   = 4;
  localparam int MODE_BIT    = 0;
  localparam int CHANNELS    = 4;

  // Serial bus address of this device.
  localparam logic [6:0] I2C_ADDR = 7'h0c;

  // Power-on reset hold time.
  localparam int         POR_TIME_NS   = 1000;
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POR_CNT_MAX   = 8'(POR_CYCLES);

  // Register map, byte addresses.
  localparam int         AV_ADDR_W   = 4;
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_FRAME   = 4'h8;

  // Status field positions.
  localparam int ST_REF_POS  = 8;
  localparam int ST_HOLD_POS = 9;
  localparam int ST_POR_POS  = 10;
  localparam int ST_MID_POS  = 11;

  // Reset values.
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
  localparam logic [7:0]  POWER_RESET   = 8'h00;

endpackage

// >>> verif/i2c_ctrl_model.sv
// Serial bus controller model that sends 24-bit command words to the control block.
`timescale 1ns/1ps
module i2c_ctrl_model (
  // Data wire level after all open-drain drivers
  input  wire logic sda_line,
  // Lines driven by the controller
  output logic      scl,
  output logic      sda_drv
);
  import quad_dac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // The clock stands high between frames and only toggles inside them.
  localparam time QTR = 16;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // Data changes a quarter period after the clock falls, well clear of the high phase.
  task automatic put_bit(input logic b, output logic seen);
    #QTR sda_drv = b;
    #QTR scl = 1'b1;
    #QTR seen = sda_line;
    #QTR scl = 1'b0;
  endtask

  // Sends the address byte and the first nbytes of the word, then a stop.
  task automatic send(input frame_t f, input int nbytes, output logic acked);
    logic [31:0] word;
    logic        seen;
    word  = {I2C_ADDR, 1'b0, 1'b0, f[22:0]};
    acked = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b0;
    for (int i = 0; i < 8 * (nbytes + 1); i++) begin
      put_bit(word[31-i], seen);
      if (i % 8 == 7) begin
        put_bit(1'b1, seen);
        acked = acked & ~seen;
      end
    end
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #QTR;
  endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the quad converter power, reset and reference control block.
`timescale 1ns/1ps
module tb;
  import quad_dac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic                 clk;
  logic                 rst_n;
  logic [AV_ADDR_W-1:0] address;
  logic                 read;
  logic                 write;
  logic [31:0]          writedata;
  logic [31:0]          readdata;
  logic                 waitrequest;
  logic                 scl;
  logic                 sda_drv;
  logic                 sda_out;
  logic                 sda_oe;
  logic                 strap;
  logic                 load_n;
  logic                 clear_n;
  logic [7:0]           power_mode;
  logic                 ref_enable;
  logic                 hold_startup;
  logic                 startup_midscale;
  logic                 por_busy;
  logic                 dac_clear;
  logic                 full_reset;
  logic                 load_evt;
  logic                 clear_evt;
  logic [7:0]           exp_pm;
  logic                 mid_nostrap;
  wire                  sda_line = sda_drv & ~(sda_oe & ~sda_out);
  int                   miscompares = 0;
  int                   n_compared = 0;
  int                   n_dac = 0;
  int                   n_full = 0;
  int                   n_load = 0;
  int                   n_clear = 0;
  power_mode_t          modes [4] = '{PM_PULL_1K, PM_PULL_100K, PM_HIGH_Z, PM_NORMAL};
  logic [3:0]           sels  [4] = '{4'h1, 4'h6, 4'h8, 4'h2};

  quad_dac_ctrl i_dut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .startup_level_pin(strap), .load_strobe_pin_n(load_n), .output_clear_pin_n(clear_n),
    .power_mode(power_mode), .ref_enable(ref_enable), .hold_startup(hold_startup),
    .startup_midscale(startup_midscale), .por_busy(por_busy), .dac_clear(dac_clear),
    .full_reset(full_reset), .load_evt(load_evt), .clear_evt(clear_evt)
  );

  // Second instance models the variant that has no strap pin; only its startup level matters.
  quad_dac_ctrl #(.HAS_STRAP_PIN(1'b0)) i_nostrap (
    .clk(clk), .rst_n(rst_n), .address(address), .read(1'b0), .write(1'b0),
    .writedata(writedata), .readdata(), .waitrequest(),
    .scl_in(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
    .startup_level_pin(strap), .load_strobe_pin_n(load_n), .output_clear_pin_n(clear_n),
    .power_mode(), .ref_enable(), .hold_startup(), .startup_midscale(mid_nostrap),
    .por_busy(), .dac_clear(), .full_reset(), .load_evt(), .clear_evt()
  );

  i2c_ctrl_model i_i2c (
    .sda_line(sda_line),
    .scl(scl),
    .sda_drv(sda_drv)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Pulses are counted so that a missing or extra one shows up later.
  always @(posedge clk) begin
    if (dac_clear === 1'b1) n_dac++;
    if (full_reset === 1'b1) n_full++;
    if (load_evt === 1'b1) n_load++;
    if (clear_evt === 1'b1) n_clear++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One bus transfer; the request holds until waitrequest is sampled low.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    // The slave inserts exactly one wait cycle; a hang is left to the watchdog.
    check(n, 2, "bus answer");
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    av(1'b0, a, 32'h0000_0000, q);
    check(q, exp, what);
  endtask

  // Sends a command; the byte-select and address fields carry noise on purpose.
  task automatic cmd(input logic [2:0] code, input logic [2:0] ch, input logic [15:0] d,
                     input int nb, input logic exp_ack);
    logic ack;
    i_i2c.send(frame_t'{reserved: 1'b0, byte_select: 1'b1, command_code: code,
                        channel_address: ch, data: d}, nb, ack);
    check(ack, exp_ack, "acknowledge");
    repeat (10) @(posedge clk);
  endtask

  initial begin
    // The tests need about 33 us; three times that means something hangs.
    #100_000;
    miscompares++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    rst_n     = 1'b0;
    address   = 4'h0;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0000_0000;
    strap     = 1'b1;
    load_n    = 1'b1;
    clear_n   = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    load_n  <= 1'b0;
    clear_n <= 1'b0;
    repeat (10) @(posedge clk);
    load_n  <= 1'b1;
    clear_n <= 1'b1;
    check(ref_enable, 0, "reference after power-up");
    check(por_busy, 1, "power-on reset running");
    repeat (200) @(posedge clk);
    check(por_busy, 0, "power-on reset over");
    check(n_load + n_clear, 0, "pin events in power-on reset");
    check(startup_midscale, 1, "startup level");
    check(mid_nostrap, 0, "startup level without strap");
    load_n  <= 1'b0;
    clear_n <= 1'b0;
    repeat (10) @(posedge clk);
    load_n  <= 1'b1;
    clear_n <= 1'b1;
    repeat (10) @(posedge clk);
    check(n_load, 1, "load event");
    check(n_clear, 1, "clear event");
    $display("Test power-on done");
    rd_chk(OFS_CONTROL, CONTROL_RESET, "control reset value");
    rd_chk(4'hC, 32'h0000_0000, "unmapped read");
    av(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    rd_chk(OFS_CONTROL, CONTROL_RESET, "control after stray write");
    rd_chk(OFS_STATUS, (32'h1 << ST_MID_POS) | (32'h1 << ST_HOLD_POS), "status");
    $display("Test registers done");
    exp_pm = POWER_RESET;
    for (int i = 0; i < 4; i++) begin
      cmd(CMD_POWER, 3'h5, {10'h3FF, modes[i], sels[i]}, 3, 1'b1);
      for (int c = 0; c < CHANNELS; c++) begin
        if (sels[i][c]) exp_pm[2*c+:2] = modes[i];
      end
      check(power_mode, exp_pm, "power mode");
    end
    rd_chk(OFS_STATUS, (32'h1 << ST_MID_POS) | (32'h1 << ST_HOLD_POS) | 32'h0000_00E1,
           "status power");
    check(n_dac, 0, "power-down keeps converter data");
    $display("Test power modes done");
    cmd(CMD_REF_SETUP, 3'h2, 16'hFFFF, 3, 1'b1);
    check(ref_enable, 1, "reference on");
    cmd(CMD_REF_SETUP, 3'h0, 16'h0000, 2, 1'b1);
    check(ref_enable, 1, "partial frame ignored");
    cmd(CMD_REF_SETUP, 3'h7, 16'hFFFE, 3, 1'b1);
    check(ref_enable, 0, "reference off");
    cmd(CMD_REF_SETUP, 3'h0, 16'h0001, 3, 1'b1);
    check(ref_enable, 1, "reference on again");
    $display("Test reference done");
    cmd(CMD_RESET, 3'h3, 16'hFFFE, 3, 1'b1);
    check(n_dac, 1, "shallow reset clears data");
    check(n_full, 0, "shallow reset depth");
    check(power_mode, exp_pm, "shallow reset keeps power");
    check(ref_enable, 1, "shallow reset keeps reference");
    cmd(CMD_RESET, 3'h0, 16'h0001, 3, 1'b1);
    check(n_dac, 2, "full reset clears data");
    check(n_full, 1, "full reset depth");
    check(power_mode, POWER_RESET, "full reset clears power");
    check(ref_enable, 0, "full reset clears reference");
    rd_chk(OFS_FRAME, 32'h0068_0001, "last committed frame");
    $display("Test software reset done");
    check(hold_startup, 1, "startup held by control commands");
    cmd(CMD_WRITE_LAST, 3'h0, 16'h1234, 2, 1'b1);
    check(hold_startup, 1, "startup held by partial write");
    cmd(CMD_WRITE_LAST, 3'h0, 16'h1234, 3, 1'b1);
    check(hold_startup, 0, "startup released by write");
    av(1'b1, OFS_CONTROL, 32'h0000_0000, q);
    cmd(CMD_REF_SETUP, 3'h0, 16'h0001, 3, 1'b0);
    check(ref_enable, 0, "disabled link ignored");
    $display("Test startup hold and link done");
    // A second power-up with the strap low must start at zero and restore the hold, reference and control defaults.
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(por_busy, 1, "second power-on reset running");
    repeat (205) @(posedge clk);
    check(por_busy, 0, "second power-on reset over");
    check(startup_midscale, 0, "startup level with strap low");
    check(hold_startup, 1, "startup held after reset");
    check(ref_enable, 0, "reference after second power-up");
    rd_chk(OFS_CONTROL, CONTROL_RESET, "control after reset");
    $display("Test second reset done");
    print_verdict();
  end
endmodule
